// [design/clksu_top.sv]
/*
 * Clock source decode, start-up timing and clock domain gating.
 * Assumes tick inputs are one-cycle pulses synchronous to clk_sys_i, one
 * per cycle of the selected source and of the watchdog oscillator.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Decode source select: 1111-1010 crystal, 1001 lf crystal, rc, int rc, 0000 ext.
// - A fuse value of one means unprogrammed, zero means programmed.
// - Wake from power-down or power-save counts source cycles before execution.
// - Start from reset adds a delay counted on the watchdog oscillator.
// - Reset delay is none, 4096 or 65536 watchdog oscillator cycles.
// - Factory default is source select 0001 with start-up select 10.
// - Crystal bits 3:1 pick range; programmed amplifier option gives 1-16 MHz.
// - Amplifier option programmed gives full swing, otherwise reduced swing.
// - Crystal, select bit 0 clear: 258 or 1K cycles with table delays.
// - Crystal, select bit 0 set: 1K or 16K cycles with table delays.
// - Some external interrupts are caught even while the i/o clock is halted.
// - Two-wire address match is caught while the i/o clock is halted.
// - The i/o clock feeds i/o modules and the external interrupt module.
// - Program memory clock runs together with the cpu clock.
// - Async timer clock domain keeps running during sleep, except in power-down.
// - Converter clock runs while cpu and i/o clocks are halted in adc noise reduction sleep.
module clksu_top #(
  parameter logic [clksu_pkg::CNT_W-1:0] WDT_LONG_TICKS = clksu_pkg::WDT_LONG_CYCLES,
  parameter logic [clksu_pkg::CNT_W-1:0] CK_16K_TICKS   = clksu_pkg::CK_16K,
  parameter logic [clksu_pkg::CNT_W-1:0] CK_32K_TICKS   = clksu_pkg::CK_32K
) (
  input  wire logic        clk_sys_i,                           // system clock
  input  wire logic        srst_i,                              // sync reset, high
  input  wire logic [3:0]  clock_source_select_fuses_i,         // source fuses
  input  wire logic [1:0]  startup_time_fuses_i,                // start-up fuses
  input  wire logic        oscillator_amplifier_option_fuse_i,  // amp option
  input  wire logic        src_clk_tick_i,                      // source cycle
  input  wire logic        watchdog_oscillator_tick_i,          // wdt osc cycle
  input  wire logic        sleep_req_i,                         // enter sleep
  input  wire logic [1:0]  sleep_mode_i,                        // sleep kind
  input  wire logic        ext_int_async_i,                     // async ext int
  input  wire logic        two_wire_interface_addr_match_i,     // address hit
  input  wire logic        async_timer_wake_i,                  // timer event
  input  wire logic        converter_done_i,                    // conversion end
  input  wire logic        wake_ack_i,                          // clear pending
  output logic [2:0]       clk_source_o,                        // source family
  output logic [2:0]       crystal_range_o,                     // crystal range
  output logic             full_swing_o,                        // rail swing
  output logic             fuse_reserved_o,                     // reserved code
  output logic             startup_busy_o,                      // counting
  output logic             core_run_o,                          // execute
  output logic             cpu_clk_en_o,                        // cpu clock
  output logic             io_clk_en_o,                         // i/o clock
  output logic             program_memory_clk_en_o,             // flash clock
  output logic             async_timer_clock_en_o,              // async timer
  output logic             converter_clock_en_o,                // adc clock
  output logic             ext_int_pending_o,                   // ext int seen
  output logic             addr_match_pending_o                 // address seen
);

  typedef enum logic [2:0] {
    ST_LOAD,
    ST_ARM,
    ST_START,
    ST_RUN,
    ST_SLEEP
  } clksu_state_e;

  clksu_state_e            st_q, st_d;
  clksu_pkg::clksu_sleep_e mode_q, mode_d;
  logic [3:0]              fuse_src_q;
  logic [1:0]              fuse_start_q;
  logic                    fuse_opt_q;
  logic                    from_reset_q;
  logic                    osc_start, wdt_start, osc_done, wdt_done;
  logic                    wake, deep;
  logic [clksu_pkg::CNT_W-1:0] osc_tgt, wdt_tgt;
  clksu_pkg::clksu_dly_e   dly;

  function automatic clksu_pkg::clksu_src_e src_of(input logic [3:0] s);
    if (s >= clksu_pkg::SEL_CRYSTAL_MIN) begin
      src_of = clksu_pkg::SRC_CRYSTAL;
    end else if (s == clksu_pkg::SEL_LF_CRYSTAL) begin
      src_of = clksu_pkg::SRC_LF_CRYSTAL;
    end else if (s >= clksu_pkg::SEL_EXT_RC_MIN) begin
      src_of = clksu_pkg::SRC_EXT_RC;
    end else if (s >= clksu_pkg::SEL_INT_RC_MIN) begin
      src_of = clksu_pkg::SRC_INT_RC;
    end else begin
      src_of = clksu_pkg::SRC_EXT_CLK;
    end
  endfunction

  // start-up cycles of the selected source
  function automatic logic [clksu_pkg::CNT_W-1:0] ck_of(input logic [3:0] s,
                                                         input logic [1:0] t);
    ck_of = clksu_pkg::CK_6;
    case (src_of(s))
      clksu_pkg::SRC_CRYSTAL: begin
        if (!s[0]) begin
          ck_of = t[1] ? clksu_pkg::CK_1K : clksu_pkg::CK_258;
        end else begin
          ck_of = (t == 2'h0) ? clksu_pkg::CK_1K : CK_16K_TICKS;
        end
      end
      clksu_pkg::SRC_LF_CRYSTAL: begin
        ck_of = t[1] ? CK_32K_TICKS : clksu_pkg::CK_1K;
      end
      clksu_pkg::SRC_EXT_RC: begin
        ck_of = (t == 2'h3) ? clksu_pkg::CK_6 : clksu_pkg::CK_18;
      end
      default: begin
        ck_of = clksu_pkg::CK_6;
      end
    endcase
  endfunction

  // extra delay after reset, counted on the watchdog oscillator
  function automatic clksu_pkg::clksu_dly_e dly_of(input logic [3:0] s,
                                                   input logic [1:0] t);
    dly_of = clksu_pkg::DLY_LONG;
    case (src_of(s))
      clksu_pkg::SRC_CRYSTAL: begin
        case ({s[0], t})
          3'h0:    dly_of = clksu_pkg::DLY_SHORT;
          3'h1:    dly_of = clksu_pkg::DLY_LONG;
          3'h2:    dly_of = clksu_pkg::DLY_NONE;
          3'h3:    dly_of = clksu_pkg::DLY_SHORT;
          3'h4:    dly_of = clksu_pkg::DLY_LONG;
          3'h5:    dly_of = clksu_pkg::DLY_NONE;
          3'h6:    dly_of = clksu_pkg::DLY_SHORT;
          default: dly_of = clksu_pkg::DLY_LONG;
        endcase
      end
      clksu_pkg::SRC_LF_CRYSTAL: begin
        dly_of = (t == 2'h0) ? clksu_pkg::DLY_SHORT : clksu_pkg::DLY_LONG;
      end
      clksu_pkg::SRC_EXT_RC: begin
        case (t)
          2'h0:    dly_of = clksu_pkg::DLY_NONE;
          2'h2:    dly_of = clksu_pkg::DLY_LONG;
          default: dly_of = clksu_pkg::DLY_SHORT;
        endcase
      end
      default: begin
        // reserved code 11 falls back to the longest delay
        case (t)
          2'h0:    dly_of = clksu_pkg::DLY_NONE;
          2'h1:    dly_of = clksu_pkg::DLY_SHORT;
          default: dly_of = clksu_pkg::DLY_LONG;
        endcase
      end
    endcase
  endfunction

  // fuses sampled once, in the cycle after reset release
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fuse_src_q <= clksu_pkg::DEFAULT_SRC_SEL;
      fuse_start_q <= clksu_pkg::DEFAULT_STARTUP;
      fuse_opt_q <= clksu_pkg::DEFAULT_OPT;
    end else if (st_q == ST_LOAD) begin
      fuse_src_q <= clock_source_select_fuses_i;
      fuse_start_q <= startup_time_fuses_i;
      fuse_opt_q <= oscillator_amplifier_option_fuse_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clk_source_o    <= 3'h0;
      crystal_range_o <= 3'h0;
      full_swing_o    <= 1'h0;
      fuse_reserved_o <= 1'h0;
    end else begin
      clk_source_o    <= src_of(fuse_src_q);
      full_swing_o    <= (fuse_opt_q == clksu_pkg::FUSE_PROGRAMMED);
      fuse_reserved_o <= (fuse_start_q == 2'h3) && (src_of(fuse_src_q) == clksu_pkg::SRC_LF_CRYSTAL
                         || src_of(fuse_src_q) == clksu_pkg::SRC_INT_RC);
      if (src_of(fuse_src_q) != clksu_pkg::SRC_CRYSTAL) begin
        crystal_range_o <= clksu_pkg::RNG_NONE;
      end else if (fuse_opt_q == clksu_pkg::FUSE_PROGRAMMED) begin
        crystal_range_o <= clksu_pkg::RNG_1P0_16P0;
      end else begin
        case (fuse_src_q[3:1])
          clksu_pkg::XTAL_CODE_LOW: crystal_range_o <= clksu_pkg::RNG_0P4_0P9;
          clksu_pkg::XTAL_CODE_MID: crystal_range_o <= clksu_pkg::RNG_0P9_3P0;
          default:                  crystal_range_o <= clksu_pkg::RNG_3P0_8P0;
        endcase
      end
    end
  end

  assign deep = (mode_q == clksu_pkg::SLP_PDOWN) || (mode_q == clksu_pkg::SLP_PSAVE);
  // interrupt and address paths do not depend on the i/o clock enable
  assign wake = ext_int_async_i || two_wire_interface_addr_match_i
                || (async_timer_wake_i && mode_q != clksu_pkg::SLP_PDOWN)
                || (converter_done_i && !deep);
  assign mode_d = (st_q == ST_RUN && sleep_req_i) ? clksu_pkg::clksu_sleep_e'(sleep_mode_i)
                                                  : mode_q;

  assign dly       = dly_of(fuse_src_q, fuse_start_q);
  assign osc_tgt   = ck_of(fuse_src_q, fuse_start_q);
  assign osc_start = (st_q == ST_ARM) || (st_q == ST_SLEEP && wake && deep);
  assign wdt_start = osc_start;

  always_comb begin
    case (dly)
      clksu_pkg::DLY_SHORT: wdt_tgt = clksu_pkg::WDT_SHORT_CYCLES;
      clksu_pkg::DLY_LONG:  wdt_tgt = WDT_LONG_TICKS;
      default:              wdt_tgt = '0;
    endcase
    if (st_q != ST_ARM || !from_reset_q) begin
      wdt_tgt = '0;
    end
  end

  clksu_tick_counter u_osc_cnt (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .start_i   (osc_start),
    .target_i  (osc_tgt),
    .tick_i    (src_clk_tick_i),
    .done_o    (osc_done)
  );

  clksu_tick_counter u_wdt_cnt (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .start_i   (wdt_start),
    .target_i  (wdt_tgt),
    .tick_i    (watchdog_oscillator_tick_i),
    .done_o    (wdt_done)
  );

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_LOAD:  st_d = ST_ARM;
      ST_ARM:   st_d = ST_START;
      ST_START: begin
        if (osc_done && wdt_done && !osc_start) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_req_i) begin
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          st_d = deep ? ST_START : ST_RUN;
        end
      end
      default:  st_d = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= ST_LOAD;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mode_q <= clksu_pkg::SLP_IDLE;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      from_reset_q <= 1'h1;
    end else if (st_q == ST_RUN) begin
      from_reset_q <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      core_run_o     <= 1'h0;
      startup_busy_o <= 1'h0;
    end else begin
      core_run_o     <= (st_d == ST_RUN);
      startup_busy_o <= (st_d == ST_START) || (st_d == ST_ARM);
    end
  end

  // clock gating per state and sleep mode
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cpu_clk_en_o            <= 1'h0;
      program_memory_clk_en_o <= 1'h0;
      io_clk_en_o             <= 1'h0;
      async_timer_clock_en_o  <= 1'h0;
      converter_clock_en_o    <= 1'h0;
    end else begin
      cpu_clk_en_o            <= (st_d == ST_RUN);
      program_memory_clk_en_o <= (st_d == ST_RUN);
      io_clk_en_o             <= (st_d == ST_RUN)
                                 || (st_d == ST_SLEEP && mode_d == clksu_pkg::SLP_IDLE);
      async_timer_clock_en_o  <= (st_d == ST_RUN)
                                 || (st_d == ST_SLEEP && mode_d != clksu_pkg::SLP_PDOWN);
      converter_clock_en_o    <= (st_d == ST_RUN)
                                 || (st_d == ST_SLEEP && mode_d != clksu_pkg::SLP_PDOWN
                                     && mode_d != clksu_pkg::SLP_PSAVE);
    end
  end

  // set wins over the acknowledge
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ext_int_pending_o <= 1'h0;
    end else if (ext_int_async_i) begin
      ext_int_pending_o <= 1'h1;
    end else if (wake_ack_i) begin
      ext_int_pending_o <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr_match_pending_o <= 1'h0;
    end else if (two_wire_interface_addr_match_i) begin
      addr_match_pending_o <= 1'h1;
    end else if (wake_ack_i) begin
      addr_match_pending_o <= 1'h0;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_deep_wake;
    st_q == ST_SLEEP && deep && wake;
  endsequence

  sequence s_held_start;
    (st_q == ST_START && !core_run_o);
  endsequence

  a_deep_wake_waits: assert property (s_deep_wake |=> s_held_start)
    else $error("deep wake skipped start-up count");

  a_reset_delay_hold: assert property (
    st_q == ST_START && !wdt_done |=> !core_run_o)
    else $error("core ran before reset delay ended");

  a_wdt_long_count: assert property (
    st_q == ST_ARM && dly == clksu_pkg::DLY_LONG |-> wdt_tgt == WDT_LONG_TICKS)
    else $error("long reset delay target wrong");

  a_release_both: assert property (
    st_q == ST_START && osc_done && wdt_done && !osc_start |=> core_run_o)
    else $error("core not released after start-up");

  a_default_fuses: assert property ($past(srst_i) |->
    fuse_src_q == clksu_pkg::DEFAULT_SRC_SEL && fuse_start_q == clksu_pkg::DEFAULT_STARTUP)
    else $error("default fuse values wrong after reset");

  a_crystal_decode: assert property (
    fuse_src_q >= clksu_pkg::SEL_CRYSTAL_MIN |=> clk_source_o == clksu_pkg::SRC_CRYSTAL)
    else $error("crystal source not decoded");

  a_range_wide: assert property (
    fuse_src_q >= clksu_pkg::SEL_CRYSTAL_MIN && fuse_opt_q == clksu_pkg::FUSE_PROGRAMMED
    |=> crystal_range_o == clksu_pkg::RNG_1P0_16P0)
    else $error("wide crystal range not chosen");

  a_swing_mode: assert property (full_swing_o == !$past(fuse_opt_q))
    else $error("amplifier swing mismatch");

  a_flash_with_cpu: assert property (
    program_memory_clk_en_o == cpu_clk_en_o)
    else $error("flash clock out of step with cpu clock");

  a_extint_caught: assert property (ext_int_async_i |=> ext_int_pending_o)
    else $error("external interrupt lost");

  a_addr_caught: assert property (
    two_wire_interface_addr_match_i |=> addr_match_pending_o)
    else $error("address match lost");

  a_adc_alone: assert property (
    st_q == ST_SLEEP && mode_q == clksu_pkg::SLP_ADC_NR
    |-> converter_clock_en_o && !io_clk_en_o && !cpu_clk_en_o)
    else $error("converter clock not alone in noise reduction");

endmodule

`default_nettype wire

// [include/clksu_pkg.sv]
/*
 * Package for the clock source and start-up control block: fuse codes,
 * start-up cycle counts, watchdog delays, and shared enumerations.
 * Assumes fuse values arrive as plain levels, 1 meaning unprogrammed.
 */
package clksu_pkg;

  typedef enum logic [2:0] {
    SRC_CRYSTAL,
    SRC_LF_CRYSTAL,
    SRC_EXT_RC,
    SRC_INT_RC,
    SRC_EXT_CLK
  } clksu_src_e;

  typedef enum logic [2:0] {
    RNG_NONE,
    RNG_0P4_0P9,
    RNG_0P9_3P0,
    RNG_3P0_8P0,
    RNG_1P0_16P0
  } clksu_range_e;

  typedef enum logic [1:0] {
    SLP_IDLE,
    SLP_ADC_NR,
    SLP_PDOWN,
    SLP_PSAVE
  } clksu_sleep_e;

  typedef enum logic [1:0] {
    DLY_NONE,
    DLY_SHORT,
    DLY_LONG
  } clksu_dly_e;

  localparam int unsigned CNT_W = 17;

  localparam logic FUSE_PROGRAMMED   = 1'h0;
  localparam logic FUSE_UNPROGRAMMED = 1'h1;

  localparam logic [3:0] SEL_CRYSTAL_MIN = 4'ha;
  localparam logic [3:0] SEL_LF_CRYSTAL  = 4'h9;
  localparam logic [3:0] SEL_EXT_RC_MIN  = 4'h5;
  localparam logic [3:0] SEL_INT_RC_MIN  = 4'h1;
  localparam logic [3:0] SEL_EXT_CLK     = 4'h0;

  localparam logic [2:0] XTAL_CODE_LOW  = 3'h5;
  localparam logic [2:0] XTAL_CODE_MID  = 3'h6;
  localparam logic [2:0] XTAL_CODE_HIGH = 3'h7;

  // shipped configuration: internal rc, longest start-up
  localparam logic [3:0] DEFAULT_SRC_SEL = 4'h1;
  localparam logic [1:0] DEFAULT_STARTUP = 2'h2;
  localparam logic       DEFAULT_OPT     = FUSE_UNPROGRAMMED;

  localparam logic [CNT_W-1:0] CK_6   = 17'h00006;
  localparam logic [CNT_W-1:0] CK_18  = 17'h00012;
  localparam logic [CNT_W-1:0] CK_258 = 17'h00102;
  localparam logic [CNT_W-1:0] CK_1K  = 17'h00400;
  localparam logic [CNT_W-1:0] CK_16K = 17'h04000;
  localparam logic [CNT_W-1:0] CK_32K = 17'h08000;

  // watchdog oscillator ticks: about 4.1 ms and 65 ms at 5 V
  localparam logic [CNT_W-1:0] WDT_SHORT_CYCLES = 17'h01000;
  localparam logic [CNT_W-1:0] WDT_LONG_CYCLES  = 17'h10000;

endpackage

// [design/clksu_tick_counter.sv]
/*
 * Down-counter of qualified ticks from a loaded target to zero.
 * Assumes tick_i is a one-cycle pulse per counted oscillator cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module clksu_tick_counter (
  input  wire logic                       clk_sys_i, // system clock
  input  wire logic                       srst_i,    // sync reset, high
  input  wire logic                       start_i,   // load target
  input  wire logic [clksu_pkg::CNT_W-1:0] target_i,  // ticks to wait
  input  wire logic                       tick_i,    // one counted cycle
  output logic                            done_o     // target reached
);

  logic [clksu_pkg::CNT_W-1:0] cnt_q;
  logic                        done_q;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= target_i;
    end else if (tick_i && cnt_q != '0) begin
      cnt_q <= cnt_q - 17'h00001;
    end
  end

  // a zero target finishes on the load edge itself
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      done_q <= 1'h0;
    end else if (start_i) begin
      done_q <= (target_i == '0);
    end else if (tick_i && cnt_q == 17'h00001) begin
      done_q <= 1'h1;
    end
  end

  assign done_o = done_q;

endmodule

`default_nettype wire

// [tb/tb_clksu_top.sv]
/*
 * Self-checking bench for clksu_top: fuse decode, start-up counts, sleep gating.
 * Assumes tick inputs are bench pulses and the design's own assertions run alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_clksu_top;
  localparam int LONG  = 40;
  localparam int SHORT = 4096;

  logic       clk_sys_i;
  logic       srst_i;
  logic [3:0] sel;
  logic [1:0] stsel;
  logic [1:0] mode;
  logic       opt, src_tk, wdt_tk, slp, ext, adr, asy, cdone, ack;
  logic [2:0] src_o, rng_o;
  logic       swing_o, rsv_o, busy_o, run_o, cpu_o, io_o, flash_o;
  logic       asy_o, adc_o, extp_o, adrp_o;
  int         n_mismatch, n_tests, c, v;
  // crystal start-up: source ticks and watchdog ticks per {bit0, start-up select}
  int         xs [8] = '{258, 258, 1024, 1024, 1024, 20, 20, 20};
  int         xw [8] = '{SHORT, LONG, 0, SHORT, LONG, 0, SHORT, LONG};
  // {io, async timer, converter} enables per sleep mode
  logic [2:0] en_exp [4] = '{3'h7, 3'h3, 3'h0, 3'h2};

  clksu_top #(
    .WDT_LONG_TICKS (17'h00028),
    .CK_16K_TICKS   (17'h00014),
    .CK_32K_TICKS   (17'h00018)
  ) DUT (
    .clk_sys_i                          (clk_sys_i),
    .srst_i                             (srst_i),
    .clock_source_select_fuses_i        (sel),
    .startup_time_fuses_i               (stsel),
    .oscillator_amplifier_option_fuse_i (opt),
    .src_clk_tick_i                     (src_tk),
    .watchdog_oscillator_tick_i         (wdt_tk),
    .sleep_req_i                        (slp),
    .sleep_mode_i                       (mode),
    .ext_int_async_i                    (ext),
    .two_wire_interface_addr_match_i    (adr),
    .async_timer_wake_i                 (asy),
    .converter_done_i                   (cdone),
    .wake_ack_i                         (ack),
    .clk_source_o                       (src_o),
    .crystal_range_o                    (rng_o),
    .full_swing_o                       (swing_o),
    .fuse_reserved_o                    (rsv_o),
    .startup_busy_o                     (busy_o),
    .core_run_o                         (run_o),
    .cpu_clk_en_o                       (cpu_o),
    .io_clk_en_o                        (io_o),
    .program_memory_clk_en_o            (flash_o),
    .async_timer_clock_en_o             (asy_o),
    .converter_clock_en_o               (adc_o),
    .ext_int_pending_o                  (extp_o),
    .addr_match_pending_o               (adrp_o)
  );

  initial begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic do_reset(input logic [3:0] cs, input logic [1:0] st, input logic o);
    sel = cs;
    stsel = st;
    opt = o;
    srst_i = 1'h1;
    repeat (4) step();
    srst_i = 1'h0;
  endtask

  // bounded wait: which=0 for busy, 1 for core run
  task automatic wait_for(input bit which);
    int k;
    for (k = 0; k < 8 && (which ? run_o : busy_o) !== 1'h1; k++) step();
  endtask

  task automatic ticks(input int ns, input int nw);
    int k;
    for (k = 0; k < ns || k < nw; k++) begin
      src_tk = (k < ns);
      wdt_tk = (k < nw);
      step();
    end
    src_tk = 1'h0;
    wdt_tk = 1'h0;
  endtask

  // one tick short must hold the core; the last tick must release it
  task automatic startup(input int ns, input int nw);
    wait_for(1'b0);
    // from reset, counters load on the edge after busy rises; a tick there is lost
    step();
    ticks(ns - 1, (nw > 0) ? nw - 1 : 0);
    repeat (2) step();
    check("core_run_early", {2'h0, run_o}, 3'h0);
    ticks(1, (nw > 0) ? 1 : 0);
    wait_for(1'b1);
    check("core_run", {busy_o, cpu_o, run_o}, 3'h3);
    check("run_enables", {flash_o, io_o, adc_o}, 3'h7);
  endtask

  function automatic logic [2:0] exp_src(input logic [3:0] cs);
    if (cs >= 4'ha) return clksu_pkg::SRC_CRYSTAL;
    if (cs == 4'h9) return clksu_pkg::SRC_LF_CRYSTAL;
    if (cs >= 4'h5) return clksu_pkg::SRC_EXT_RC;
    if (cs >= 4'h1) return clksu_pkg::SRC_INT_RC;
    return clksu_pkg::SRC_EXT_CLK;
  endfunction

  function automatic logic [2:0] exp_rng(input logic [3:0] cs, input logic o);
    if (cs < 4'ha) return clksu_pkg::RNG_NONE;
    if (!o) return clksu_pkg::RNG_1P0_16P0;
    case (cs[3:1])
      3'h5: return clksu_pkg::RNG_0P4_0P9;
      3'h6: return clksu_pkg::RNG_0P9_3P0;
      default: return clksu_pkg::RNG_3P0_8P0;
    endcase
  endfunction

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {src_tk, wdt_tk, slp, ext, adr, asy, cdone, ack} = 8'h00;
    mode = 2'h0;
    n_mismatch = 0;
    n_tests = 0;
    for (c = 0; c < 16; c++) begin
      for (v = 0; v < 2; v++) begin
        do_reset(4'(c), v[0] ? 2'h3 : 2'h0, v[0]);
        wait_for(1'b0);
        // decode outputs still show the default fuses on the busy edge
        step();
        check("clk_source", src_o, exp_src(4'(c)));
        check("crystal_range", rng_o, exp_rng(4'(c), v[0]));
        check("full_swing", {2'h0, swing_o}, {2'h0, ~v[0]});
        check("fuse_reserved", {2'h0, rsv_o}, {2'h0, v[0] && (c == 9 || (c > 0 && c < 5))});
      end
    end
    for (c = 0; c < 8; c++) begin
      do_reset({3'h7, c[2]}, c[1:0], 1'h0);
      startup(xs[c], xw[c]);
    end
    // shipped fuse setting: internal rc, long reset delay
    do_reset(4'h1, 2'h2, 1'h1);
    wait_for(1'b0);
    check("default_source", src_o, clksu_pkg::SRC_INT_RC);
    startup(6, LONG);
    for (c = 0; c < 4; c++) begin
      mode = c[1:0];
      slp = 1'h1;
      step();
      slp = 1'h0;
      check("sleep_core", {cpu_o, flash_o, run_o}, 3'h0);
      check("sleep_enables", {io_o, asy_o, adc_o}, en_exp[c]);
      if (c < 2) begin
        cdone = (c == 0);
        asy = (c == 1);
        step();
        cdone = 1'h0;
        asy = 1'h0;
        wait_for(1'b1);
        check("light_wake", {cpu_o, io_o, run_o}, 3'h7);
      end else begin
        ext = (c == 2);
        adr = (c == 3);
        step();
        ext = 1'h0;
        adr = 1'h0;
        step();
        check("pending", {1'h0, extp_o, adrp_o}, {1'h0, c == 2, c == 3});
        startup(6, 0);
        ack = 1'h1;
        step();
        ack = 1'h0;
        step();
        check("pending_clear", {1'h0, extp_o, adrp_o}, 3'h0);
      end
    end
    end_of_test();
  end
endmodule

`default_nettype wire
